// File: ieg_pkg.sv
// ieg_pkg: addresses, field positions, write masks and reset values of the
// interrupt enable registers, plus the index of each gated request source.
// assumes an 8-bit special-function-register port on the core clock.
package ieg_pkg;

    // register addresses on the sfr port
    localparam logic [7:0] IEG_ADDR_PRIMARY     = 8'h A8;
    localparam logic [7:0] IEG_ADDR_SECONDARY_B = 8'h B8;
    localparam logic [7:0] IEG_ADDR_SECONDARY_C = 8'h 9A;
    localparam logic [7:0] IEG_ADDR_SECONDARY_D = 8'h BE;

    // reset values
    localparam logic [7:0] IEG_RST_PRIMARY     = 8'h00;
    localparam logic [7:0] IEG_RST_SECONDARY_B = 8'h00;
    localparam logic [7:0] IEG_RST_SECONDARY_C = 8'h00;
    localparam logic [7:0] IEG_RST_SECONDARY_D = 8'h00;

    // implemented bits; reserved bits are not stored and read as zero
    localparam logic [7:0] IEG_MASK_PRIMARY     = 8'hFF;
    localparam logic [7:0] IEG_MASK_SECONDARY_B = 8'hFF;
    localparam logic [7:0] IEG_MASK_SECONDARY_C = 8'h3D;
    localparam logic [7:0] IEG_MASK_SECONDARY_D = 8'h0C;

    // primary register fields
    localparam int IEG_P_PIN_IRQ0    = 0;
    localparam int IEG_P_TIMER0_OVF  = 1;
    localparam int IEG_P_PIN_IRQ1    = 2;
    localparam int IEG_P_TIMER1_OVF  = 3;
    localparam int IEG_P_SERIAL_CH0  = 4;
    localparam int IEG_P_TIMER2      = 5;
    localparam int IEG_P_WDOG_REFR   = 6;
    localparam int IEG_P_GLOBAL_GATE = 7;

    // secondary b register fields
    localparam int IEG_B_CONV_DONE     = 0;
    localparam int IEG_B_PIN_IRQ2      = 1;
    localparam int IEG_B_WDOG_START    = 6;
    localparam int IEG_B_TIMER2_RELOAD = 7;

    // secondary c register fields
    localparam int IEG_C_SERIAL_CH1  = 0;
    localparam int IEG_C_CMP_BANK    = 2;
    localparam int IEG_C_CMP_TIMER   = 3;
    localparam int IEG_C_CMP_SET     = 4;
    localparam int IEG_C_CMP_CLR     = 5;

    // secondary d register fields
    localparam int IEG_D_CMP1_TIMER  = 2;
    localparam int IEG_D_CMP1_CAPCMP = 3;

    // request source indices on the req/periph_en/irq_req vectors
    localparam int IEG_NSRC          = 20;
    localparam int IEG_S_PIN_IRQ0    = 0;
    localparam int IEG_S_TIMER0_OVF  = 1;
    localparam int IEG_S_PIN_IRQ1    = 2;
    localparam int IEG_S_TIMER1_OVF  = 3;
    localparam int IEG_S_SERIAL_CH0  = 4;
    localparam int IEG_S_TIMER2      = 5;
    localparam int IEG_S_CONV_DONE   = 6;
    localparam int IEG_S_PIN_IRQ2    = 7;   // pin irqs 2..6 use 7..11
    localparam int IEG_S_NPIN_HI     = 5;
    localparam int IEG_S_T2_RELOAD   = 12;
    localparam int IEG_S_SERIAL_CH1  = 13;
    localparam int IEG_S_CMP_BANK    = 14;
    localparam int IEG_S_CMP_TIMER   = 15;
    localparam int IEG_S_CMP_SET     = 16;
    localparam int IEG_S_CMP_CLR     = 17;
    localparam int IEG_S_CMP1_TIMER  = 18;
    localparam int IEG_S_CMP1_CAPCMP = 19;

endpackage

// File: ieg_req_gate.sv
// ieg_req_gate: per-source AND of flag, own enable, peripheral enable and
// global gate, registered toward the priority and acknowledge logic.
// assumes all inputs synchronous to sys_clk.
`timescale 1ns/1ps
`default_nettype none
module ieg_req_gate #(
    parameter int N = 20
) (
    input  wire logic         sys_clk,
    input  wire logic         nrst,
    input  wire logic [N-1:0] src_flag,
    input  wire logic [N-1:0] src_enable,
    input  wire logic [N-1:0] periph_enable,
    input  wire logic         global_gate,
    output logic      [N-1:0] gated_req
);
    logic [N-1:0] req_d;
    logic [N-1:0] req_q;

    // per-source gating, one term per source
    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_src
            // RQ14: all four terms
            always_comb begin
                req_d[g] = src_flag[g] & src_enable[g] & periph_enable[g] & global_gate;
            end
        end
    endgenerate

    // request register
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            req_q <= '0;
        end else begin
            req_q <= req_d;
        end
    end

    assign gated_req = req_q;
endmodule
`default_nettype wire

// File: ieg_top.sv
// ieg_top: interrupt enable registers on the sfr port and the gating of
// every interrupt request by its enable bits and the global gate.
// assumes a single-cycle sfr write/read port from the core, inputs synchronous.
// Function
// RQ1: each source has its own enable bit
// RQ2: global gate low blocks every request
// RQ3: global gate high, per-source bit decides
// RQ4: reset clears all four enable registers
// RQ5: peripheral enable also required where present
// RQ6: primary bits 0,2 gate pin irqs
// RQ7: primary bits 1,3 gate timer overflows
// RQ8: primary bits 4,5 gate serial0, timer2
// RQ9: bit 6 is watchdog, not gating
// RQ10: secondary b bit 0 gates converter
// RQ11: secondary b bits 1-5 gate pin irqs 2-6
// RQ12: bit 7 gates only reload interrupt
// RQ13: third register gates compare and serial1
// RQ14: request needs flag, enables and global gate
`timescale 1ns/1ps
`default_nettype none
module ieg_top
    import ieg_pkg::*;
(
    input  wire logic                    sys_clk,
    input  wire logic                    nrst,
    input  wire logic [7:0]              sfr_addr,
    input  wire logic                    sfr_wr,
    input  wire logic [7:0]              sfr_wdata,
    input  wire logic                    sfr_rd,
    output logic      [7:0]              sfr_rdata,
    output logic                         sfr_hit,
    input  wire logic [ieg_pkg::IEG_NSRC-1:0] src_flag,
    input  wire logic [ieg_pkg::IEG_NSRC-1:0] periph_en,
    output logic      [ieg_pkg::IEG_NSRC-1:0] irq_req,
    output logic                         wdog_refresh_bit,
    output logic                         wdog_start_bit
);
    import ieg_pkg::*;

    logic [7:0] primary_q, primary_d;
    logic [7:0] sec_b_q, sec_b_d;
    logic [7:0] sec_c_q, sec_c_d;
    logic [7:0] sec_d_q, sec_d_d;
    logic [7:0] rdata_q, rdata_d;
    logic       hit_q, hit_d;
    logic       wdog_refr_q, wdog_refr_d;
    logic       wdog_start_q, wdog_start_d;
    logic [IEG_NSRC-1:0] src_en;

    // register writes, reserved bits masked off
    always_comb begin
        primary_d    = primary_q;
        sec_b_d      = sec_b_q;
        sec_c_d      = sec_c_q;
        sec_d_d      = sec_d_q;
        // RQ1: software sets or clears
        if (sfr_wr) begin
            case (sfr_addr)
                IEG_ADDR_PRIMARY:     primary_d = sfr_wdata & IEG_MASK_PRIMARY;
                IEG_ADDR_SECONDARY_B: sec_b_d   = sfr_wdata & IEG_MASK_SECONDARY_B;
                IEG_ADDR_SECONDARY_C: sec_c_d   = sfr_wdata & IEG_MASK_SECONDARY_C;
                IEG_ADDR_SECONDARY_D: sec_d_d   = sfr_wdata & IEG_MASK_SECONDARY_D;
                default: ;
            endcase
        end
    end

    // RQ4: all disabled at reset
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            primary_q <= IEG_RST_PRIMARY;
            sec_b_q   <= IEG_RST_SECONDARY_B;
            sec_c_q   <= IEG_RST_SECONDARY_C;
            sec_d_q   <= IEG_RST_SECONDARY_D;
        end else begin
            primary_q <= primary_d;
            sec_b_q   <= sec_b_d;
            sec_c_q   <= sec_c_d;
            sec_d_q   <= sec_d_d;
        end
    end

    // read path, answer one cycle after the read strobe
    always_comb begin
        rdata_d = 8'h00;
        hit_d   = 1'b0;
        if (sfr_rd) begin
            hit_d = 1'b1;
            case (sfr_addr)
                IEG_ADDR_PRIMARY:     rdata_d = primary_q;
                IEG_ADDR_SECONDARY_B: rdata_d = sec_b_q;
                IEG_ADDR_SECONDARY_C: rdata_d = sec_c_q;
                IEG_ADDR_SECONDARY_D: rdata_d = sec_d_q;
                default:              hit_d   = 1'b0;
            endcase
        end
    end

    // watchdog bits: a write of one pulses the request for one cycle
    always_comb begin
        // RQ9: watchdog bits not gating
        wdog_refr_d  = sfr_wr && (sfr_addr == IEG_ADDR_PRIMARY)
                       && sfr_wdata[IEG_P_WDOG_REFR];
        wdog_start_d = sfr_wr && (sfr_addr == IEG_ADDR_SECONDARY_B)
                       && sfr_wdata[IEG_B_WDOG_START];
    end

    // read data and watchdog pulse registers
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rdata_q      <= 8'h00;
            hit_q        <= 1'b0;
            wdog_refr_q  <= 1'b0;
            wdog_start_q <= 1'b0;
        end else begin
            rdata_q      <= rdata_d;
            hit_q        <= hit_d;
            wdog_refr_q  <= wdog_refr_d;
            wdog_start_q <= wdog_start_d;
        end
    end

    // map each source to its own enable bit
    always_comb begin
        src_en = '0;
        // RQ6: pin irq 0 and 1
        src_en[IEG_S_PIN_IRQ0]   = primary_q[IEG_P_PIN_IRQ0];
        src_en[IEG_S_PIN_IRQ1]   = primary_q[IEG_P_PIN_IRQ1];
        // RQ7: timer overflow enables
        src_en[IEG_S_TIMER0_OVF] = primary_q[IEG_P_TIMER0_OVF];
        src_en[IEG_S_TIMER1_OVF] = primary_q[IEG_P_TIMER1_OVF];
        // RQ8: serial0 and timer2
        src_en[IEG_S_SERIAL_CH0] = primary_q[IEG_P_SERIAL_CH0];
        src_en[IEG_S_TIMER2]     = primary_q[IEG_P_TIMER2];
        // RQ10: converter done enable
        src_en[IEG_S_CONV_DONE]  = sec_b_q[IEG_B_CONV_DONE];
        // RQ11: pin irqs 2 to 6
        for (int i = 0; i < IEG_S_NPIN_HI; i++) begin
            src_en[IEG_S_PIN_IRQ2 + i] = sec_b_q[IEG_B_PIN_IRQ2 + i];
        end
        // RQ12: reload interrupt only
        src_en[IEG_S_T2_RELOAD]  = sec_b_q[IEG_B_TIMER2_RELOAD];
        // RQ13: compare and serial1 enables
        src_en[IEG_S_SERIAL_CH1] = sec_c_q[IEG_C_SERIAL_CH1];
        src_en[IEG_S_CMP_BANK]   = sec_c_q[IEG_C_CMP_BANK];
        src_en[IEG_S_CMP_TIMER]  = sec_c_q[IEG_C_CMP_TIMER];
        src_en[IEG_S_CMP_SET]    = sec_c_q[IEG_C_CMP_SET];
        src_en[IEG_S_CMP_CLR]    = sec_c_q[IEG_C_CMP_CLR];
        src_en[IEG_S_CMP1_TIMER]  = sec_d_q[IEG_D_CMP1_TIMER];
        src_en[IEG_S_CMP1_CAPCMP] = sec_d_q[IEG_D_CMP1_CAPCMP];
    end

    // RQ2: global gate on every source
    // RQ3: own bit decides when high
    // RQ5: peripheral enable joins the AND
    ieg_req_gate #(
        .N (IEG_NSRC)
    ) u_gate (
        .sys_clk       (sys_clk),
        .nrst          (nrst),
        .src_flag      (src_flag),
        .src_enable    (src_en),
        .periph_enable (periph_en),
        .global_gate   (primary_q[IEG_P_GLOBAL_GATE]),
        .gated_req     (irq_req)
    );

    assign sfr_rdata        = rdata_q;
    assign sfr_hit          = hit_q;
    assign wdog_refresh_bit = wdog_refr_q;
    assign wdog_start_bit   = wdog_start_q;
endmodule
`default_nettype wire

// File: ieg_src_model.sv
// ieg_src_model: request sources and peripheral enables for ieg_top.
// assumes commands change on the rising edge.
`timescale 1ns/1ps
`default_nettype none
module ieg_src_model (
    input  wire logic        sys_clk,
    input  wire logic [19:0] flag_cmd,
    input  wire logic [19:0] pen_cmd,
    output logic      [19:0] src_flag = 20'h00000,
    output logic      [19:0] periph_en = 20'h00000
);
    // levels move off the sampling edge
    always @(negedge sys_clk) begin
        src_flag <= flag_cmd;
        periph_en <= pen_cmd;
    end
endmodule
`default_nettype wire

// File: ieg_monitor.sv
// ieg_monitor: port assertions on ieg_top, bound below.
// assumes sys_clk rising edge, nrst asynchronous low.
`timescale 1ns/1ps
`default_nettype none
module ieg_monitor
    import ieg_pkg::*;
(
    input wire logic        sys_clk,
    input wire logic        nrst,
    input wire logic [7:0]  sfr_addr,
    input wire logic        sfr_wr,
    input wire logic [7:0]  sfr_wdata,
    input wire logic        sfr_rd,
    input wire logic [7:0]  sfr_rdata,
    input wire logic        sfr_hit,
    input wire logic [19:0] src_flag,
    input wire logic [19:0] periph_en,
    input wire logic [19:0] irq_req,
    input wire logic        wdog_refresh_bit,
    input wire logic        wdog_start_bit
);
    logic g_q, g_d, wr_p, wr_b, map;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    // decode of the strobes
    assign wr_p = sfr_wr && sfr_addr == IEG_ADDR_PRIMARY;
    assign wr_b = sfr_wr && sfr_addr == IEG_ADDR_SECONDARY_B;
    assign map = sfr_addr inside {IEG_ADDR_PRIMARY, IEG_ADDR_SECONDARY_B,
        IEG_ADDR_SECONDARY_C, IEG_ADDR_SECONDARY_D};
    // shadow of the global gate bit
    always_comb g_d = wr_p ? sfr_wdata[IEG_P_GLOBAL_GATE] : g_q;
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) g_q <= 1'b0;
        else g_q <= g_d;
    end
    a_gate_blocks_all:
    assert property (!$past(g_q) |-> irq_req == 20'h00000) else $error("gate off");
    a_req_needs_src:
    assert property ((irq_req & ~$past(src_flag & periph_en)) == 20'h00000)
        else $error("request without source");
    a_map_rd_hit:
    assert property (sfr_rd && map |=> sfr_hit) else $error("no hit");
    a_unmapped_rd:
    assert property (sfr_rd && !map |=> !sfr_hit && sfr_rdata == 8'h00)
        else $error("unmapped read");
    a_rdata_idle:
    assert property (!sfr_rd |=> !sfr_hit && sfr_rdata == 8'h00) else $error("idle rdata");
    a_rsvd_c_zero:
    assert property (sfr_rd && sfr_addr == IEG_ADDR_SECONDARY_C |=>
        (sfr_rdata & ~IEG_MASK_SECONDARY_C) == 8'h00) else $error("reserved bits");
    a_wdog_refresh:
    assert property (wr_p |=> wdog_refresh_bit == $past(sfr_wdata[IEG_P_WDOG_REFR]))
        else $error("refresh pulse");
    a_wdog_start:
    assert property (wr_b |=> wdog_start_bit == $past(sfr_wdata[IEG_B_WDOG_START]))
        else $error("start pulse");
    a_wdog_quiet:
    assert property (!wr_p && !wr_b |=> !wdog_refresh_bit && !wdog_start_bit)
        else $error("stray pulse");
    c_irq_any: cover property (irq_req != 20'h00000);
    c_unmapped: cover property (sfr_rd && !map);
    c_refresh: cover property (wdog_refresh_bit);
endmodule
bind ieg_top ieg_monitor u_mon (.*);
`default_nettype wire

// File: interrupt_enable_gating_tb.sv
// interrupt_enable_gating_tb: random register and gating checks.
// assumes ieg_top, ieg_src_model and the bound monitor.
`timescale 1ns/1ps
`default_nettype none
module interrupt_enable_gating_tb;
    import ieg_pkg::*;
    localparam logic [7:0] AD[4] = '{IEG_ADDR_PRIMARY, IEG_ADDR_SECONDARY_B,
        IEG_ADDR_SECONDARY_C, IEG_ADDR_SECONDARY_D};
    localparam logic [7:0] MK[4] = '{IEG_MASK_PRIMARY, IEG_MASK_SECONDARY_B,
        IEG_MASK_SECONDARY_C, IEG_MASK_SECONDARY_D};
    logic        sys_clk = 0, nrst = 0, sfr_wr = 0, sfr_rd = 0, chk = 0, pr = 0, pi = 0;
    logic [7:0]  sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata, w, rv[4];
    logic        sfr_hit, wdog_refresh_bit, wdog_start_bit;
    logic [19:0] flag_cmd = 20'h00000, pen_cmd = 20'h00000, src_flag, periph_en, irq_req;
    logic [19:0] exp_q[$];
    int          err_count = 0, checked = 0, cyc = 0;
    ieg_top dut (.*);
    ieg_src_model u_src (.*);
    initial forever #5 sys_clk = ~sys_clk;
    task automatic compare(input logic [19:0] seen, input logic [19:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic finish_test();
        $display("checked=%0d err_count=%0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // one register access; a read notes its expected hit and data
    task automatic acc(input logic wr, input logic [7:0] a, d, input logic [19:0] e);
        @(negedge sys_clk);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = wr;
        sfr_rd = !wr;
        if (!wr) exp_q.push_back(e);
        @(negedge sys_clk);
        sfr_wr = 0;
        sfr_rd = 0;
    endtask
    // apply flags and enables, note the gated result
    task automatic gate(input logic [19:0] f, p);
        @(posedge sys_clk);
        flag_cmd <= f;
        pen_cmd <= p;
        @(negedge sys_clk);
        chk = 1;
        exp_q.push_back(f & p & {20{rv[0][7]}} & {rv[3][3:2], rv[2][5:2], rv[2][0],
            rv[1][7], rv[1][5:0], rv[0][5:0]});
        @(negedge sys_clk);
        chk = 0;
    endtask
    task automatic do_reset();
        nrst = 0;
        repeat (10) @(negedge sys_clk);
        nrst = 1;
        rv = '{default: 8'h00};
        foreach (AD[i]) acc(0, AD[i], 8'h00, 20'h00100);
    endtask
    // result watcher and hang limit
    always @(posedge sys_clk) begin
        pr <= sfr_rd;
        pi <= chk;
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            finish_test();
        end
    end
    always @(negedge sys_clk) begin
        if (pr) compare({11'h000, sfr_hit, sfr_rdata}, exp_q.pop_front());
        if (pi) compare(irq_req, exp_q.pop_front());
    end
    initial begin
        void'($urandom(44471));
        do_reset();
        repeat (60) begin
            foreach (AD[i]) begin
                w = 8'($urandom());
                rv[i] = w & MK[i];
                acc(1, AD[i], w, 20'h00000);
                acc(0, AD[i], 8'h00, {12'h001, rv[i]});
            end
            acc(1, 8'hA9, 8'hFF, 20'h00000);
            acc(0, 8'hA9, 8'h00, 20'h00000);
            gate(20'($urandom()), 20'($urandom()));
            gate(20'($urandom()), 20'hFFFFF);
        end
        do_reset();
        gate(20'hFFFFF, 20'hFFFFF);
        // let the watcher take the last note before the verdict
        repeat (2) @(negedge sys_clk);
        compare(20'(exp_q.size()), 20'h00000);
        finish_test();
    end
endmodule
`default_nettype wire
